// ===== rtl/sslm_pkg.sv
package sslm_pkg;

   // Register byte offsets on the APB bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LEVEL = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_SLOTS = 8'h0C;
   localparam logic [7:0] OFS_LOW_LIMIT = 8'h10;
   localparam logic [7:0] OFS_SILENT_LIMIT = 8'h14;
   localparam logic [7:0] OFS_STEP = 8'h18;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFS_PHASE = 8'h24;

   // Control register field positions
   localparam int CTRL_AVG_BIT = 0;
   localparam int CTRL_COMP_BIT = 1;

   // Interrupt status field positions
   localparam int IRQ_STALL_BIT = 0;
   localparam int IRQ_UPDATE_BIT = 1;
   localparam int IRQ_WIDTH = 2;

   // Widths and ranges
   localparam int IND_W = 8;
   localparam int RES_W = 9;
   localparam int SLOTS = 4;
   localparam int PER_W = 20;
   localparam logic [8:0] LOAD_MAX = 9'h1FE;

   // Values after reset
   localparam logic [7:0] LEVEL_RST = 8'h00;
   localparam logic [8:0] RESULT_RST = 9'h000;
   localparam logic [19:0] LOW_LIMIT_RST = 20'h00000;
   localparam logic [19:0] SILENT_LIMIT_RST = 20'h00000;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;

endpackage : sslm_pkg

// ===== rtl/sslm_slot_if.sv
`timescale 1ns/1ps
`default_nettype none

// Write port and registered contents of the per-transition store
interface sslm_slot_if;
   logic wr_en;
   logic [1:0] wr_idx;
   logic [7:0] wr_data;
   logic [7:0] slot [4];

   modport ctrl (output wr_en, output wr_idx, output wr_data, input slot);
   modport store (input wr_en, input wr_idx, input wr_data, output slot);
endinterface : sslm_slot_if

`default_nettype wire

// ===== rtl/sslm_slot_mem.sv
`timescale 1ns/1ps
`default_nettype none

module sslm_slot_mem (
   input wire logic pclk,
   input wire logic presetn,
   sslm_slot_if.store port
);

   // One register per zero-crossing slot, read straight from the flops
   genvar gi;
   generate
      for (gi = 0; gi < sslm_pkg::SLOTS; gi++) begin : g_slot
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               port.slot[gi] <= 8'h00;
            end else if (port.wr_en && port.wr_idx == 2'(gi)) begin
               port.slot[gi] <= port.wr_data;
            end
         end
      end
   endgenerate

endmodule : sslm_slot_mem

`default_nettype wire

// ===== rtl/sslm_top.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module sslm_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic meas_valid,
   input wire logic [1:0] meas_index,
   input wire logic [7:0] meas_value,
   input wire logic silent_mode,
   input wire logic [19:0] measured_step_period,
   output logic fault_indicator_out,
   output logic [8:0] phase_offset,
   output logic [8:0] load_result,
   output logic irq
);

   sslm_slot_if slots ();

   // Software-visible control state
   logic load_average_on_reg;
   logic phase_jump_comp_on_reg;
   logic [7:0] stall_compare_level_reg;
   logic [19:0] lower_speed_period_limit_reg;
   logic [19:0] silent_mode_period_limit_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;

   // Datapath state
   logic upd_pend_reg;
   logic [8:0] load_result_reg;
   logic [8:0] load_result_next;
   logic stall_pulse_reg;
   logic silent_prev_reg;
   logic [8:0] phase_offset_reg;
   logic irq_reg;

   // Bus state, then window, stall and slot-sum nets
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic bus_write;
   logic addr_hit;
   logic diag_window;
   logic stall_seen;
   logic [9:0] slot_sum;

   // Write strobe at the completing access edge
   assign bus_write = psel && penable && pready_reg && pwrite;

   // Address decode for the mapped words
   always_comb begin
      unique case (paddr)
         sslm_pkg::OFS_CTRL,
         sslm_pkg::OFS_LEVEL,
         sslm_pkg::OFS_RESULT,
         sslm_pkg::OFS_SLOTS,
         sslm_pkg::OFS_LOW_LIMIT,
         sslm_pkg::OFS_SILENT_LIMIT,
         sslm_pkg::OFS_STEP,
         sslm_pkg::OFS_IRQ_STATUS,
         sslm_pkg::OFS_IRQ_MASK,
         sslm_pkg::OFS_PHASE: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   // Answer is prepared in the setup cycle; access completes at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready_reg <= 1'b1;
         pslverr_reg <= !addr_hit;
         prdata_reg <= 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               sslm_pkg::OFS_CTRL: begin
                  prdata_reg[sslm_pkg::CTRL_AVG_BIT] <= load_average_on_reg;
                  prdata_reg[sslm_pkg::CTRL_COMP_BIT] <=
                     phase_jump_comp_on_reg;
               end
               sslm_pkg::OFS_LEVEL: prdata_reg[7:0] <= stall_compare_level_reg;
               sslm_pkg::OFS_RESULT: prdata_reg[8:0] <= load_result_reg;
               sslm_pkg::OFS_SLOTS: prdata_reg <= {slots.slot[3],
                  slots.slot[2], slots.slot[1], slots.slot[0]};
               sslm_pkg::OFS_LOW_LIMIT:
                  prdata_reg[19:0] <= lower_speed_period_limit_reg;
               sslm_pkg::OFS_SILENT_LIMIT:
                  prdata_reg[19:0] <= silent_mode_period_limit_reg;
               sslm_pkg::OFS_STEP: prdata_reg[19:0] <= measured_step_period;
               sslm_pkg::OFS_IRQ_STATUS: prdata_reg[1:0] <= irq_status_reg;
               sslm_pkg::OFS_IRQ_MASK: prdata_reg[1:0] <= irq_mask_reg;
               sslm_pkg::OFS_PHASE: prdata_reg[8:0] <= phase_offset_reg;
               default: prdata_reg <= 32'h0000_0000;
            endcase
         end
      end else if (psel && penable && pready_reg) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // Control register: averaging and phase compensation switches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_average_on_reg <= 1'b0;
         phase_jump_comp_on_reg <= 1'b0;
      end else if (bus_write && paddr == sslm_pkg::OFS_CTRL) begin
         load_average_on_reg <= pwdata[sslm_pkg::CTRL_AVG_BIT];
         phase_jump_comp_on_reg <= pwdata[sslm_pkg::CTRL_COMP_BIT];
      end
   end

   // Stall comparison level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_compare_level_reg <= sslm_pkg::LEVEL_RST;
      end else if (bus_write && paddr == sslm_pkg::OFS_LEVEL) begin
         stall_compare_level_reg <= pwdata[7:0];
      end
   end

   // Speed window limits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lower_speed_period_limit_reg <= sslm_pkg::LOW_LIMIT_RST;
         silent_mode_period_limit_reg <= sslm_pkg::SILENT_LIMIT_RST;
      end else if (bus_write) begin
         if (paddr == sslm_pkg::OFS_LOW_LIMIT) begin
            lower_speed_period_limit_reg <= pwdata[19:0];
         end
         if (paddr == sslm_pkg::OFS_SILENT_LIMIT) begin
            silent_mode_period_limit_reg <= pwdata[19:0];
         end
      end
   end

   // Crossing lands in its own slot only while averaging
   assign slots.wr_en = meas_valid;
   assign slots.wr_idx = load_average_on_reg ? meas_index : 2'h0;
   assign slots.wr_data = meas_value;

   sslm_slot_mem u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .port(slots)
   );

   // Result is computed one cycle after the slot write lands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upd_pend_reg <= 1'b0;
      end else begin
         upd_pend_reg <= meas_valid;
      end
   end

   // Sum of four slots halved keeps one fractional bit of the mean
   assign slot_sum = {2'b00, slots.slot[0]} + {2'b00, slots.slot[1]} +
      {2'b00, slots.slot[2]} + {2'b00, slots.slot[3]};

   // Next load result, 0 to 510 in both modes
   always_comb begin
      if (load_average_on_reg) begin
         load_result_next = slot_sum[9:1];
      end else begin
         load_result_next = {slots.slot[0], 1'b0};
      end
   end

   // Load result register, updated one cycle after every crossing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_result_reg <= sslm_pkg::RESULT_RST;
      end else if (upd_pend_reg) begin
         load_result_reg <= load_result_next;
      end
   end

   // Stall window: silent chopper and step period inside the limits
   assign diag_window = silent_mode &&
      (lower_speed_period_limit_reg >= measured_step_period) &&
      (measured_step_period > silent_mode_period_limit_reg);

   // Comparison made once per update against the fresh result
   assign stall_seen = upd_pend_reg &&
      (load_result_next < {1'b0, stall_compare_level_reg});

   // One-cycle diagnostic pulse per failing update
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_pulse_reg <= 1'b0;
      end else begin
         stall_pulse_reg <= stall_seen && diag_window;
      end
   end

   // Phase offset: captured entering current mode, dropped on return
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         silent_prev_reg <= 1'b1;
         phase_offset_reg <= 9'h000;
      end else begin
         silent_prev_reg <= silent_mode;
         if (!phase_jump_comp_on_reg) begin
            phase_offset_reg <= 9'h000;
         end else if (silent_prev_reg && !silent_mode) begin
            phase_offset_reg <= sslm_pkg::LOAD_MAX - load_result_reg;
         end else if (!silent_prev_reg && silent_mode) begin
            phase_offset_reg <= 9'h000;
         end
      end
   end

   // Sticky event bits; a new event wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= 2'h0;
      end else begin
         for (int i = 0; i < sslm_pkg::IRQ_WIDTH; i++) begin
            if (bus_write && paddr == sslm_pkg::OFS_IRQ_STATUS &&
                pwdata[i]) begin
               irq_status_reg[i] <= 1'b0;
            end
         end
         if (stall_seen && diag_window) begin
            irq_status_reg[sslm_pkg::IRQ_STALL_BIT] <= 1'b1;
         end
         if (upd_pend_reg) begin
            irq_status_reg[sslm_pkg::IRQ_UPDATE_BIT] <= 1'b1;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= sslm_pkg::IRQ_MASK_RST;
      end else if (bus_write && paddr == sslm_pkg::OFS_IRQ_MASK) begin
         irq_mask_reg <= pwdata[1:0];
      end
   end

   // Level interrupt, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign fault_indicator_out = stall_pulse_reg;
   assign phase_offset = phase_offset_reg;
   assign load_result = load_result_reg;
   assign irq = irq_reg;

endmodule : sslm_top

`default_nettype wire

// ===== dv/sslm_motor_model.sv
`timescale 1ns/1ps
`default_nettype none

// Coil crossings toward the block, motion controller on its fault output
module sslm_motor_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fault_indicator_out,
   output logic meas_valid,
   output logic [1:0] meas_index,
   output logic [7:0] meas_value,
   output logic silent_mode,
   output logic [19:0] measured_step_period
);
   int pulses = 0;

   // Quiet lines before the first crossing
   initial begin
      meas_valid = 1'b0;
      meas_index = 2'h0;
      meas_value = 8'h00;
      silent_mode = 1'b1;
      measured_step_period = 20'h00000;
   end

   // The controller counts every pulse seen out of reset
   always @(posedge pclk) begin
      if (presetn && fault_indicator_out) pulses <= pulses + 1;
   end

   // One zero crossing per call; calls may follow back to back
   task automatic crossing(input logic [1:0] i, input logic [7:0] v);
      meas_valid <= 1'b1;
      meas_index <= i;
      meas_value <= v;
      @(posedge pclk);
   endtask : crossing

   // Idle lines carry inverted data so stale values never match
   task automatic idle(input int n);
      meas_valid <= 1'b0;
      meas_index <= ~meas_index;
      meas_value <= ~meas_value;
      repeat (n) @(posedge pclk);
   endtask : idle

   // Chopper mode and step period from the motion side, no crossing
   task automatic set_mode(input logic s, input logic [19:0] p);
      meas_valid <= 1'b0;
      silent_mode <= s;
      measured_step_period <= p;
      @(posedge pclk);
   endtask : set_mode
endmodule : sslm_motor_model

`default_nettype wire

// ===== dv/sslm_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Port checks for the load and stall block
module sslm_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic meas_valid,
   input wire logic silent_mode,
   input wire logic fault_indicator_out,
   input wire logic [8:0] phase_offset,
   input wire logic [8:0] load_result
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Access phase, and a crossing taken two edges back
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_update;
      $past(meas_valid, 2);
   endsequence

   property p_ready;
      s_access |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready in access");
   property p_range;
      load_result <= 9'h1FE;
   endproperty
   a_range: assert property (p_range) else $error("result high");
   property p_level;
      fault_indicator_out |-> load_result < 9'h0FF;
   endproperty
   a_level: assert property (p_level) else $error("pulse at high");
   property p_cause;
      fault_indicator_out |-> s_update;
   endproperty
   a_cause: assert property (p_cause) else $error("pulse no update");
   property p_hold;
      !$past(meas_valid, 2) |-> $stable(load_result);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_mode;
      fault_indicator_out |-> $past(silent_mode);
   endproperty
   a_mode: assert property (p_mode) else $error("pulse not silent");
   property p_pulse;
      fault_indicator_out && !$past(meas_valid) |=> !fault_indicator_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse held");
   property p_phase;
      silent_mode && $past(silent_mode) |-> phase_offset == 9'h000;
   endproperty
   a_phase: assert property (p_phase) else $error("offset kept");
endmodule : sslm_chk

bind sslm_top sslm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .meas_valid(meas_valid),
   .silent_mode(silent_mode), .fault_indicator_out(fault_indicator_out),
   .phase_offset(phase_offset), .load_result(load_result));

`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata, rd_data;
   logic pready, pslverr, meas_valid, silent_mode, fault_indicator_out, irq;
   logic rd_err;
   logic [1:0] meas_index;
   logic [7:0] meas_value;
   logic [19:0] measured_step_period;
   logic [8:0] phase_offset, load_result;
   int mismatches = 0;
   int checks_done = 0;

   // Bus clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   sslm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .meas_valid(meas_valid), .meas_index(meas_index),
      .meas_value(meas_value), .silent_mode(silent_mode),
      .measured_step_period(measured_step_period),
      .fault_indicator_out(fault_indicator_out),
      .phase_offset(phase_offset), .load_result(load_result), .irq(irq));
   sslm_motor_model mdl (.pclk(pclk), .presetn(presetn),
      .fault_indicator_out(fault_indicator_out), .meas_valid(meas_valid),
      .meas_index(meas_index), .meas_value(meas_value),
      .silent_mode(silent_mode),
      .measured_step_period(measured_step_period));

   // Compare and count
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next call never re-raises psel in this step
      @(posedge pclk);
      if (n >= 20) mismatches++;
   endtask : apb

   // Register read with comparison
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h00000000);
      check(nm, rd_data, e);
   endtask : rd

   // Values after reset and an unmapped place
   task automatic t_reset();
      rd(sslm_pkg::OFS_LEVEL, 32'h00000000, "level");
      rd(sslm_pkg::OFS_CTRL, 32'h00000000, "ctrl");
      rd(8'h3C, 32'h00000000, "unmapped");
      check("slverr", {31'h0, rd_err}, 32'h00000001);
      $display("test reset done");
   endtask : t_reset

   // Unfiltered update lands in slot zero, doubled
   task automatic t_single();
      mdl.crossing(2'h2, 8'h40);
      mdl.idle(2);
      @(negedge pclk);
      check("result", {23'h0, load_result}, 32'h00000080);
      @(posedge pclk);
      rd(sslm_pkg::OFS_SLOTS, 32'h00000040, "slot0");
      mdl.crossing(2'h3, 8'hFF);
      mdl.idle(2);
      rd(sslm_pkg::OFS_RESULT, 32'h000001FE, "full");
      $display("test single done");
   endtask : t_single

   // Stall pulse, interrupt, level and speed window edges
   task automatic t_stall();
      // Half of the lowest result seen so far (0x080)
      apb(1'b1, sslm_pkg::OFS_LEVEL, 32'h00000040);
      apb(1'b1, sslm_pkg::OFS_LOW_LIMIT, 32'h00000200);
      apb(1'b1, sslm_pkg::OFS_SILENT_LIMIT, 32'h00000080);
      apb(1'b1, sslm_pkg::OFS_IRQ_MASK, 32'h00000001);
      mdl.set_mode(1'b1, 20'h00100);
      mdl.crossing(2'h0, 8'h10);
      mdl.idle(4);
      check("pulses", mdl.pulses, 32'h00000001);
      check("irq", {31'h0, irq}, 32'h00000001);
      rd(sslm_pkg::OFS_IRQ_STATUS, 32'h00000003, "status");
      apb(1'b1, sslm_pkg::OFS_IRQ_STATUS, 32'h00000003);
      mdl.idle(2);
      check("irq clear", {31'h0, irq}, 32'h00000000);
      // Result equal to the level, judged inside the window
      mdl.crossing(2'h0, 8'h20);
      mdl.idle(1);
      // Step period equal to the silent limit, judged before mode changes
      mdl.set_mode(1'b1, 20'h00080);
      mdl.crossing(2'h0, 8'h10);
      mdl.idle(1);
      // Current mode with the period back inside the limits
      mdl.set_mode(1'b0, 20'h00100);
      mdl.crossing(2'h0, 8'h10);
      mdl.idle(3);
      check("no pulse", mdl.pulses, 32'h00000001);
      check("any mode", {23'h0, load_result}, 32'h00000020);
      check("offset none", {23'h0, phase_offset}, 32'h00000000);
      mdl.set_mode(1'b1, 20'h00200);
      mdl.crossing(2'h0, 8'h10);
      mdl.idle(4);
      check("edge pulse", mdl.pulses, 32'h00000002);
      $display("test stall done");
   endtask : t_stall

   // Four slots, mean of the latest four
   task automatic t_avg();
      apb(1'b1, sslm_pkg::OFS_CTRL, 32'h00000001);
      mdl.crossing(2'h0, 8'h0A);
      mdl.crossing(2'h1, 8'h14);
      mdl.crossing(2'h2, 8'h1E);
      mdl.crossing(2'h3, 8'h29);
      mdl.idle(2);
      rd(sslm_pkg::OFS_SLOTS, 32'h291E140A, "slots");
      rd(sslm_pkg::OFS_RESULT, 32'h00000032, "mean");
      $display("test average done");
   endtask : t_avg

   // Offset stored leaving silent mode, dropped on return
   task automatic t_phase();
      apb(1'b1, sslm_pkg::OFS_CTRL, 32'h00000002);
      mdl.crossing(2'h0, 8'h40);
      mdl.idle(3);
      mdl.set_mode(1'b0, 20'h00100);
      mdl.idle(2);
      check("offset", {23'h0, phase_offset}, 32'h0000017E);
      mdl.set_mode(1'b1, 20'h00100);
      mdl.idle(2);
      check("offset off", {23'h0, phase_offset}, 32'h00000000);
      $display("test phase done");
   endtask : t_phase

   // Counts and verdict
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial begin
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h00000000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_single();
      t_stall();
      t_avg();
      t_phase();
      tally_and_finish();
   end

   // Hang guard
   initial begin
      repeat (3000) @(posedge pclk);
      mismatches++;
      tally_and_finish();
   end
endmodule : tb_top

`default_nettype wire
